//--- rtl/sss_consts.vh
// What this block does
// - pot output rises while increase held, falls while decrease held
// - upward ramp rate set by a rise time, ten seconds by default
// - downward ramp rate set by a separate fall time, ten seconds default
// - start value, zero by default, loaded at first motor switch-on
// - bit 0 clear reloads start value; set restores value kept at switch-off
// - automatic mode: bit 1 clear gives instant change, set applies ramps
// - manual mode always applies the ramp times
// - bit 2 set softens ramp start so tiny changes can be entered
// - bit 3 keeps stored value across reset but not power-on reset, only with bit 0 set
// - bit 4 clear updates only with pulses enabled; set updates always
// - configuration bits reset to 00110
// - pot output clamped between lower and upper limits, both zero default
// - a selectable source value can be loaded into the pot
// - sixteen fixed setpoints selected by the four fixed-select digital inputs
// - direct mode sums the fixed setpoints of the four active select bits
// - binary mode uses the four select bits as index into sixteen setpoints
// - mode field equal to one means direct, anything else binary
// - main and additional setpoints each routable to fixed setpoint output
// - fieldbus source takes the second process word of the frame
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SSS_OFF_CFG 8'h00
`define SSS_OFF_RISE 8'h04
`define SSS_OFF_FALL 8'h08
`define SSS_OFF_INIT 8'h0C
`define SSS_OFF_UPPER 8'h10
`define SSS_OFF_LOWER 8'h14
`define SSS_OFF_LOADV 8'h18
`define SSS_OFF_ROUTE 8'h1C
`define SSS_OFF_STAT 8'h20
`define SSS_OFF_FIXED 8'h40
// ----------------------------------------------------------------
// fields, reset values, timing
// ----------------------------------------------------------------
`define SSS_CFG_RETAIN 0
`define SSS_CFG_AUTORAMP 1
`define SSS_CFG_ROUND 2
`define SSS_CFG_NV 3
`define SSS_CFG_FREE 4
`define SSS_CFG_RST 5'h06
`define SSS_TIME_RST_MS 16'h2710
`define SSS_CLK_MHZ 100
`define SSS_CYC_PER_MS (`SSS_CLK_MHZ * 1000)
`define SSS_REF_RPM 32'h0000_05DC
`define SSS_ROUND_RPM 16'h0010
`define SSS_SRC_ZERO 2'h0
`define SSS_SRC_POT 2'h1
`define SSS_SRC_FIXED 2'h2
`define SSS_SRC_BUS 2'h3
`define SSS_MODE_DIRECT 2'h1
`define SSS_RESP_OKAY 2'h0
`define SSS_RESP_SLVERR 2'h2
`endif

//--- rtl/sss_setpoint.v
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`include "sss_consts.vh"
`default_nettype none

module sss_setpoint (
  input wire i_clk,
  input wire i_rst,
  input wire i_por,
  input wire i_pot_increase_cmd,
  input wire i_pot_decrease_cmd,
  input wire i_auto_manual_select,
  input wire i_switch_on,
  input wire i_pulse_enable,
  input wire i_pot_load,
  input wire [3:0] i_fixed_select,
  input wire [15:0] i_second_process_word,
  input wire [7:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [7:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  output reg [15:0] o_pot_value,
  output reg [15:0] o_fixed_setpoint,
  output reg [15:0] o_main_setpoint,
  output reg [15:0] o_additional_setpoint
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // limit a signed speed to [lo, hi]
  function [15:0] clamp;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if ($signed(v) > $signed(hi)) begin
        clamp = hi;
      end else if ($signed(v) < $signed(lo)) begin
        clamp = lo;
      end else begin
        clamp = v;
      end
    end
  endfunction

  // merge a bus write into a 16-bit register by its two low byte lanes
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] st;
    begin
      merge16[7:0] = st[0] ? wd[7:0] : old[7:0];
      merge16[15:8] = st[1] ? wd[15:8] : old[15:8];
    end
  endfunction

  // route a source code to a setpoint value
  function [15:0] route;
    input [1:0] sel;
    input [15:0] pot;
    input [15:0] fix;
    input [15:0] bus;
    begin
      case (sel)
        `SSS_SRC_POT: route = pot;
        `SSS_SRC_FIXED: route = fix;
        `SSS_SRC_BUS: route = bus;
        default: route = 16'h0000;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg [25:0] sync1_q;
  reg [25:0] sync2_q;
  wire [25:0] pins_w = {i_second_process_word, i_fixed_select, i_pot_load,
    i_pulse_enable, i_switch_on, i_auto_manual_select,
    i_pot_decrease_cmd, i_pot_increase_cmd};

  // two flops before any logic reads a pin
  always @(posedge i_clk) begin
    if (i_rst) begin
      sync1_q <= 26'h000_0000;
      sync2_q <= 26'h000_0000;
    end else begin
      sync1_q <= pins_w;
      sync2_q <= sync1_q;
    end
  end

  wire inc_w = sync2_q[0];
  wire dec_w = sync2_q[1];
  wire auto_w = sync2_q[2];
  wire on_w = sync2_q[3];
  wire pulse_w = sync2_q[4];
  wire load_w = sync2_q[5];
  wire [3:0] fsel_w = sync2_q[9:6];
  wire [15:0] bus_word_w = sync2_q[25:10];

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  reg [4:0] cfg_q;
  reg [15:0] rise_q;
  reg [15:0] fall_q;
  reg [15:0] init_q;
  reg [15:0] upper_q;
  reg [15:0] lower_q;
  reg [15:0] loadv_q;
  reg [4:0] route_q;
  reg [15:0] fixed_mem [0:15];
  reg [15:0] pot_q;

  wire wr_go_w = i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid;
  wire rd_go_w = i_s_axi_arvalid && !o_s_axi_rvalid;
  wire [7:0] wa_w = {i_s_axi_awaddr[7:2], 2'b00};
  wire [7:0] ra_w = {i_s_axi_araddr[7:2], 2'b00};
  wire wfix_w = wa_w[7:6] == 2'b01;
  wire rfix_w = ra_w[7:6] == 2'b01;

  // write decode; address and data are taken together
  reg wok_d;
  always @* begin
    case (wa_w)
      `SSS_OFF_CFG, `SSS_OFF_RISE, `SSS_OFF_FALL, `SSS_OFF_INIT,
      `SSS_OFF_UPPER, `SSS_OFF_LOWER, `SSS_OFF_LOADV,
      `SSS_OFF_ROUTE: wok_d = 1'b1;
      default: wok_d = wfix_w;
    endcase
  end

  integer i;
  // register writes
  always @(posedge i_clk) begin
    if (i_rst) begin
      cfg_q <= `SSS_CFG_RST;
      rise_q <= `SSS_TIME_RST_MS;
      fall_q <= `SSS_TIME_RST_MS;
      init_q <= 16'h0000;
      upper_q <= 16'h0000;
      lower_q <= 16'h0000;
      loadv_q <= 16'h0000;
      route_q <= 5'h00;
      for (i = 0; i < 16; i = i + 1) begin
        fixed_mem[i] <= 16'h0000;
      end
    end else if (wr_go_w) begin
      case (wa_w)
        `SSS_OFF_CFG: cfg_q <= i_s_axi_wstrb[0] ? i_s_axi_wdata[4:0] : cfg_q;
        `SSS_OFF_RISE: rise_q <= merge16(rise_q, i_s_axi_wdata, i_s_axi_wstrb);
        `SSS_OFF_FALL: fall_q <= merge16(fall_q, i_s_axi_wdata, i_s_axi_wstrb);
        `SSS_OFF_INIT: init_q <= merge16(init_q, i_s_axi_wdata, i_s_axi_wstrb);
        `SSS_OFF_UPPER: upper_q <= merge16(upper_q, i_s_axi_wdata, i_s_axi_wstrb);
        `SSS_OFF_LOWER: lower_q <= merge16(lower_q, i_s_axi_wdata, i_s_axi_wstrb);
        `SSS_OFF_LOADV: loadv_q <= merge16(loadv_q, i_s_axi_wdata, i_s_axi_wstrb);
        `SSS_OFF_ROUTE: route_q <= i_s_axi_wstrb[0] ? i_s_axi_wdata[4:0] : route_q;
        default: begin
          if (wfix_w) begin
            fixed_mem[wa_w[5:2]] <= merge16(fixed_mem[wa_w[5:2]], i_s_axi_wdata,
              i_s_axi_wstrb);
          end
        end
      endcase
    end
  end

  // read mux
  reg [31:0] rdat_d;
  reg rok_d;
  always @* begin
    rok_d = 1'b1;
    case (ra_w)
      `SSS_OFF_CFG: rdat_d = {27'h0, cfg_q};
      `SSS_OFF_RISE: rdat_d = {16'h0, rise_q};
      `SSS_OFF_FALL: rdat_d = {16'h0, fall_q};
      `SSS_OFF_INIT: rdat_d = {16'h0, init_q};
      `SSS_OFF_UPPER: rdat_d = {16'h0, upper_q};
      `SSS_OFF_LOWER: rdat_d = {16'h0, lower_q};
      `SSS_OFF_LOADV: rdat_d = {16'h0, loadv_q};
      `SSS_OFF_ROUTE: rdat_d = {27'h0, route_q};
      `SSS_OFF_STAT: rdat_d = {9'h000, pulse_w, auto_w, on_w, fsel_w, pot_q};
      default: begin
        rdat_d = rfix_w ? {16'h0, fixed_mem[ra_w[5:2]]} : 32'h0000_0000;
        rok_d = rfix_w;
      end
    endcase
  end

  // bus handshakes and responses
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `SSS_RESP_OKAY;
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rresp <= `SSS_RESP_OKAY;
      o_s_axi_rdata <= 32'h0000_0000;
    end else begin
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_arready <= 1'b0;
      if (wr_go_w && !o_s_axi_awready) begin
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wok_d ? `SSS_RESP_OKAY : `SSS_RESP_SLVERR;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
      if (rd_go_w && !o_s_axi_arready) begin
        o_s_axi_arready <= 1'b1;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= rdat_d;
        o_s_axi_rresp <= rok_d ? `SSS_RESP_OKAY : `SSS_RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // potentiometer emulator
  // ----------------------------------------------------------------
  reg [31:0] acc_q;
  reg [31:0] per_up_q;
  reg [31:0] per_dn_q;
  reg [15:0] saved_q;
  reg keep_q;
  reg [15:0] soft_q;
  reg on_prev_q;
  reg load_prev_q;
  reg half_q;

  wire up_w = inc_w && !dec_w;
  wire dn_w = dec_w && !inc_w;
  // ramps skipped in automatic mode with bit 1 clear, and whenever the selected ramp time is zero
  wire instant_w = auto_w && !cfg_q[`SSS_CFG_AUTORAMP];
  wire run_w = pulse_w || cfg_q[`SSS_CFG_FREE];
  wire [31:0] per_w = up_w ? per_up_q : per_dn_q;
  wire [31:0] acc_w = acc_q + `SSS_REF_RPM;
  wire hit_w = acc_w >= per_w;
  wire soft_w = cfg_q[`SSS_CFG_ROUND] && soft_q < `SSS_ROUND_RPM;
  wire [15:0] next_w = up_w ? pot_q + 16'h0001 : pot_q - 16'h0001;
  wire keep_nv_w = cfg_q[`SSS_CFG_NV] && cfg_q[`SSS_CFG_RETAIN];

  // ramp period in cycles for one full reference sweep
  always @(posedge i_clk) begin
    if (i_rst) begin
      per_up_q <= 32'h0000_0000;
      per_dn_q <= 32'h0000_0000;
    end else begin
      per_up_q <= rise_q * `SSS_CYC_PER_MS;
      per_dn_q <= fall_q * `SSS_CYC_PER_MS;
    end
  end

  // value kept across switch-off, survives reset when stored non-volatile
  always @(posedge i_clk) begin
    if (i_por) begin
      saved_q <= 16'h0000;
      keep_q <= 1'b0;
    end else if (i_rst) begin
      if (!keep_q) begin
        saved_q <= 16'h0000;
      end
    end else begin
      keep_q <= keep_nv_w; // latched, since reset clears the config bits at once
      if (on_prev_q && !on_w) begin
        saved_q <= pot_q;
      end
    end
  end

  // output integration, loading and clamping
  always @(posedge i_clk) begin
    if (i_rst) begin
      pot_q <= 16'h0000;
      acc_q <= 32'h0000_0000;
      soft_q <= 16'h0000;
      half_q <= 1'b0;
      on_prev_q <= 1'b0;
      load_prev_q <= 1'b0;
    end else begin
      on_prev_q <= on_w;
      load_prev_q <= load_w;
      if (on_w && !on_prev_q) begin
        if (cfg_q[`SSS_CFG_RETAIN]) begin
          pot_q <= clamp(saved_q, lower_q, upper_q);
        end else begin
          pot_q <= clamp(init_q, lower_q, upper_q);
        end
        acc_q <= 32'h0000_0000;
      end else if (load_w && !load_prev_q) begin
        pot_q <= clamp(route_q[4] ? bus_word_w : loadv_q,
          lower_q, upper_q);
      end else if (!run_w || !(up_w || dn_w)) begin
        acc_q <= 32'h0000_0000;
        soft_q <= 16'h0000;
        pot_q <= clamp(pot_q, lower_q, upper_q);
      end else if (instant_w || per_w == 32'h0000_0000) begin
        pot_q <= up_w ? upper_q : lower_q;
      end else if (hit_w) begin
        acc_q <= acc_w - per_w;
        half_q <= !half_q;
        // soft start steps at half rate for the first few rpm
        if (!soft_w || half_q) begin
          pot_q <= clamp(next_w, lower_q, upper_q);
          soft_q <= soft_q + 16'h0001;
        end
      end else begin
        acc_q <= acc_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // fixed setpoints and routing
  // ----------------------------------------------------------------
  reg [15:0] fix_d;
  always @* begin
    if (route_q[1:0] == `SSS_MODE_DIRECT) begin
      // sum of enabled entries, zero with none selected
      fix_d = (fsel_w[0] ? fixed_mem[0] : 16'h0000) +
        (fsel_w[1] ? fixed_mem[1] : 16'h0000) +
        (fsel_w[2] ? fixed_mem[2] : 16'h0000) +
        (fsel_w[3] ? fixed_mem[3] : 16'h0000);
    end else begin
      fix_d = fixed_mem[fsel_w];
    end
  end

  // registered setpoint outputs
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_pot_value <= 16'h0000;
      o_fixed_setpoint <= 16'h0000;
      o_main_setpoint <= 16'h0000;
      o_additional_setpoint <= 16'h0000;
    end else begin
      o_pot_value <= pot_q;
      o_fixed_setpoint <= fix_d;
      o_main_setpoint <= route(route_q[3:2], pot_q, fix_d,
        bus_word_w);
      // additional source field shares route bits 4 and 1
      o_additional_setpoint <= route({route_q[4], route_q[1]}, pot_q, fix_d,
        bus_word_w);
    end
  end

endmodule // sss_setpoint

`default_nettype wire

//--- testbench/sss_ctrl_model.sv
`default_nettype none
// ----------------------------------------
// higher-level controller model
// ----------------------------------------
module sss_ctrl_model (
  input wire logic i_clk,
  input wire logic i_up,
  input wire logic i_down,
  input wire logic [3:0] i_sel,
  input wire logic [15:0] i_word,
  output logic o_up,
  output logic o_down,
  output logic [3:0] o_sel,
  output logic [15:0] o_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins idle low until the first command
  initial {o_up, o_down, o_sel, o_word} = '0;
  // commands reach the pins right after an edge
  always @(posedge i_clk) begin
    o_up <= i_up;
    o_down <= i_down;
    o_sel <= i_sel;
    o_word <= i_word;
  end
endmodule // sss_ctrl_model
`default_nettype wire

//--- testbench/sss_setpoint_checker.sv
`default_nettype none
// ----------------------------------------
// port checker of the setpoint block
// ----------------------------------------
module sss_setpoint_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pot_increase_cmd,
  input wire logic i_pot_decrease_cmd,
  input wire logic i_auto_manual_select,
  input wire logic i_switch_on,
  input wire logic i_pot_load,
  input wire logic i_s_axi_awvalid,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_awready,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  input wire logic [15:0] o_pot_value,
  input wire logic [15:0] o_fixed_setpoint
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // motor on, no load pulse, no bus write: pot moves only by command
  wire quiet = i_switch_on && !i_pot_load && !i_s_axi_awvalid;
  // reset clears the pot and fixed setpoint outputs
  rst_zero_a: assert property (disable iff (1'b0) i_rst |=>
    o_pot_value == 16'h0000 && o_fixed_setpoint == 16'h0000) else $error("outputs not cleared");
  wr_answer_a: assert property (i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid &&
    !o_s_axi_awready |=> o_s_axi_awready && o_s_axi_wready && o_s_axi_bvalid)
    else $error("write not answered");
  b_release_a: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
    else $error("write response not released");
  rd_answer_a: assert property (i_s_axi_arvalid && !o_s_axi_rvalid && !o_s_axi_arready
    |=> o_s_axi_arready && o_s_axi_rvalid) else $error("read not answered");
  r_release_a: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
    else $error("read data not released");
  refuse_zero_a: assert property (o_s_axi_rvalid && o_s_axi_rresp == 2'h2 |->
    o_s_axi_rdata == 32'h0000_0000) else $error("refused read carries data");
  dec_no_rise_a: assert property ((quiet && i_pot_decrease_cmd && !i_pot_increase_cmd) [*8] |=>
    $signed(o_pot_value) <= $signed($past(o_pot_value))) else $error("pot rose on decrease");
  inc_no_fall_a: assert property ((quiet && i_pot_increase_cmd && !i_pot_decrease_cmd) [*8] |=>
    $signed(o_pot_value) >= $signed($past(o_pot_value))) else $error("pot fell on increase");
  manual_step_a: assert property ((quiet && !i_auto_manual_select) [*8] |=>
    (o_pot_value - $past(o_pot_value)) inside {16'h0000, 16'h0001, 16'hFFFF})
    else $error("manual pot jumped");
  // main scenarios
  wr_c: cover property (o_s_axi_bvalid && i_s_axi_bready);
  refuse_c: cover property (o_s_axi_rvalid && o_s_axi_rresp == 2'h2);
  ramp_c: cover property ((quiet && !i_auto_manual_select && i_pot_increase_cmd) [*8]);
endmodule // sss_setpoint_checker
bind sss_setpoint sss_setpoint_checker u_chk (.i_clk, .i_rst, .i_pot_increase_cmd,
  .i_pot_decrease_cmd, .i_auto_manual_select, .i_switch_on, .i_pot_load, .i_s_axi_awvalid,
  .i_s_axi_wvalid, .o_s_axi_awready, .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_bready,
  .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata,
  .o_s_axi_rresp, .o_pot_value, .o_fixed_setpoint);
`default_nettype wire

//--- testbench/testbench.sv
`default_nettype none
// ----------------------------------------
// setpoint block testbench
// ----------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, i_por, amode, sw, pulse, load, up, down;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] sel;
  logic [15:0] word;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rd_d;
  logic [1:0] rd_r, wr_r;
  wire up_w, down_w, awready, wready, bvalid, arready, rvalid;
  wire [3:0] sel_w;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] word_w, pot, fixed, main_sp, add_sp;
  int err_count, tests_run;
  sss_ctrl_model ctl (.i_clk(i_clk), .i_up(up), .i_down(down), .i_sel(sel), .i_word(word),
    .o_up(up_w), .o_down(down_w), .o_sel(sel_w), .o_word(word_w));
  sss_setpoint uut (.i_clk(i_clk), .i_rst(i_rst), .i_por(i_por),
    .i_pot_increase_cmd(up_w), .i_pot_decrease_cmd(down_w), .i_auto_manual_select(amode),
    .i_switch_on(sw), .i_pulse_enable(pulse), .i_pot_load(load), .i_fixed_select(sel_w),
    .i_second_process_word(word_w), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_pot_value(pot), .o_fixed_setpoint(fixed), .o_main_setpoint(main_sp),
    .o_additional_setpoint(add_sp));
  // 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_rng(input string n, input logic [15:0] lo, hi, s);
    tests_run++;
    if ($isunknown(s) || $signed(s) < $signed(lo) || $signed(s) > $signed(hi)) begin
      err_count++;
      $display("wrong value %s expected %h..%h seen %h", n, lo, hi, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // bus write: each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    n = 0;
    do begin
      @(negedge i_clk);
      {ta, tw, tb, wr_r} = {awready, wready, bvalid, bresp};
      n++;
      @(posedge i_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (tb !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (n >= 50) begin
      err_count++;
      end_of_test;
    end
  endtask
  // bus read: data and response taken where rvalid is seen
  task automatic rd(input logic [7:0] a);
    logic ta, tv;
    int n;
    @(posedge i_clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    n = 0;
    do begin
      @(negedge i_clk);
      {ta, tv, rd_d, rd_r} = {arready, rvalid, rdata, rresp};
      n++;
      @(posedge i_clk);
      if (ta) arvalid <= 1'b0;
    end while (tv !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (n >= 50) begin
      err_count++;
      end_of_test;
    end
  endtask
  task automatic t_regs;
    logic [7:0] ad [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [15:0] ex [6] = '{16'h0006, 16'h2710, 16'h2710, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 6; i++) begin
      rd(ad[i]);
      chk("reset value", ex[i], rd_d);
    end
    wr(8'h00, 32'hFFFF_FFFF);
    chk("write resp", 32'h0000_0000, wr_r);
    rd(8'h00);
    chk("cfg width", 32'h0000_001F, rd_d);
    wr(8'h30, 32'h0000_0001);
    chk("refused write", 32'h0000_0002, wr_r);
    rd(8'h30);
    chk("unmapped resp", 32'h0000_0002, rd_r);
  endtask
  task automatic t_fixed;
    logic [15:0] e;
    for (int i = 0; i < 16; i++) wr(8'h40 + 8'(4 * i), 32'(17 * (i + 1)));
    for (int m = 0; m < 4; m++) begin
      wr(8'h1C, 32'(8 + m));
      for (int s = 0; s < 16; s++) begin
        sel <= 4'(s);
        cyc(8);
        e = 16'(17 * (s + 1));
        if (m == 1) e = 16'(17 * (s[0] + 2 * s[1] + 3 * s[2] + 4 * s[3]));
        chk("fixed", e, fixed);
        chk("main fixed", e, main_sp);
      end
    end
  endtask
  task automatic t_bus;
    wr(8'h1C, 32'h0000_001E);
    word <= 16'hF830;
    cyc(8);
    chk("main bus", 32'h0000_F830, main_sp);
    chk("additional bus", 32'h0000_F830, add_sp);
  endtask
  // switch the motor off and on again
  task automatic cycle_on;
    sw <= 1'b0;
    cyc(8);
    sw <= 1'b1;
    cyc(8);
  endtask
  // one load strobe, then let the value settle
  task automatic pulse_load;
    load <= 1'b1;
    cyc(4);
    load <= 1'b0;
    cyc(8);
  endtask
  task automatic t_pot;
    wr(8'h1C, 32'h0000_0004);
    wr(8'h10, 32'h0000_03E8);
    wr(8'h0C, 32'h0000_00C8);
    wr(8'h00, 32'h0000_0000);
    {amode, pulse, sw} <= 3'b111;
    cyc(8);
    chk("start value", 32'h0000_00C8, main_sp);
    rd(8'h20);
    chk("status", 32'h007F_00C8, rd_d);
    up <= 1'b1;
    cyc(8);
    chk("auto jump", 32'h0000_03E8, pot);
    up <= 1'b0;
    cycle_on;
    chk("reload start", 32'h0000_00C8, pot);
    wr(8'h00, 32'h0000_0001);
    up <= 1'b1;
    cyc(8);
    up <= 1'b0;
    cycle_on;
    chk("retained", 32'h0000_03E8, pot);
    pulse <= 1'b0;
    down <= 1'b1;
    cyc(8);
    chk("no pulses", 32'h0000_03E8, pot);
    wr(8'h00, 32'h0000_0011);
    cyc(8);
    chk("free run", 32'h0000_0000, pot);
    down <= 1'b0;
  endtask
  task automatic t_limit;
    wr(8'h18, 32'h0000_012C);
    pulse_load;
    chk("load value", 32'h0000_012C, pot);
    wr(8'h10, 32'h0000_00FA);
    cyc(8);
    chk("upper clamp", 32'h0000_00FA, pot);
  endtask
  task automatic t_ramp;
    logic [4:0] cf [3] = '{5'h00, 5'h04, 5'h00};
    logic [15:0] lo [3] = '{16'h020F, 16'h0200, 16'h01D5};
    logic [15:0] hi [3] = '{16'h0213, 16'h0204, 16'h01D9};
    wr(8'h04, 32'h0000_0001);
    wr(8'h08, 32'h0000_0001);
    wr(8'h10, 32'h0000_03E8);
    wr(8'h18, 32'h0000_01F4);
    {amode, pulse} <= 2'b01;
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 32'(cf[i]));
      pulse_load;
      if (i == 2) down <= 1'b1;
      else up <= 1'b1;
      cyc(2000);
      {up, down} <= 2'b00;
      cyc(8);
      chk_rng("ramp", lo[i], hi[i], pot);
    end
  endtask
  // value kept over a mid-run reset only when stored non-volatile
  task automatic t_nv(input logic [4:0] c, input logic [15:0] e);
    wr(8'h00, 32'(c));
    wr(8'h18, 32'h0000_0190);
    pulse_load;
    sw <= 1'b0;
    cyc(8);
    i_rst <= 1'b1;
    cyc(2);
    i_rst <= 1'b0;
    wr(8'h10, 32'h0000_03E8);
    wr(8'h00, 32'(c));
    sw <= 1'b1;
    cyc(8);
    chk("kept over reset", {16'h0000, e}, pot);
  endtask
  // reset, then every scenario in turn
  initial begin
    {i_rst, i_por} = 2'b11;
    {amode, sw, pulse, load, up, down, awvalid, wvalid, bready, arvalid, rready} = '0;
    {sel, word, awaddr, araddr, wdata} = '0;
    {err_count, tests_run} = '0;
    cyc(20);
    {i_rst, i_por} <= 2'b00;
    t_regs;
    t_fixed;
    t_bus;
    t_pot;
    t_limit;
    t_ramp;
    t_nv(5'h09, 16'h0190);
    t_nv(5'h01, 16'h0000);
    end_of_test;
  end
  // watchdog well beyond the seven thousand cycles the run needs
  initial begin
    #400000;
    err_count++;
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
